/* File: iuv_monitor.sv */
// Input undervoltage warning and fault monitor with register port and fault response sequencer
// Function
// - Warn when measured input voltage is below the warning threshold.
// - Fault when measured input voltage is below the fault threshold.
// - Threshold bits 15:11 are read-only and return the configured exponent.
// - Threshold bits 10:0 are a writable eleven-bit mantissa.
// - Threshold value is mantissa times two to the exponent.
// - Reaction bits 7:6 pick fault response; code 00 ignores the fault.
// - Code 01 keeps running delay one, then shuts down and retries.
// - Code 10 shuts down at once and retries per retry field.
// - Code 11 disables output while fault lasts, re-enables when cleared.
// - Reaction bits 5:3 set number of restart attempts.
// - Fault remaining after all retries keeps output disabled until cleared.
// - Latched fault is cleared only by device reset.
// - Interval between restart attempts equals delay two.
// - Delay code picks delay one from 10 ms doubling, delay two from 252 ms.
`timescale 1ns/1ps
module iuv_monitor #(
    parameter int TICK_CYCLES = iuv_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata_r,
    input wire logic [15:0] inputVoltageSense,
    input wire logic senseValid,
    input wire logic [4:0] exponentSetting,
    output logic warnFlag_r,
    output logic faultFlag_r,
    output logic outputEnable_r,
    output logic faultLatched_r
);
    ////////////////////////////////////////////////////////////////////////
    iuv_timer_if tif();
    iuv_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tif(tif)
    );

    // Scaled threshold, saturated so a large exponent cannot wrap into a low limit
    function automatic logic [15:0] scale(input logic [10:0] mant, input logic [4:0] expo);
        logic [47:0] wide;
        wide = 48'(mant) << expo;
        scale = (wide > 48'h00000000FFFF) ? 16'hFFFF : wide[15:0];
    endfunction

    function automatic logic [11:0] delay1Ms(input logic [2:0] code);
        delay1Ms = 12'(iuv_pkg::DELAY1_BASE_MS << code);
    endfunction

    // Delay two is not a clean doubling: base, two odd steps, then equal steps
    function automatic logic [11:0] delay2Ms(input logic [2:0] code);
        delay2Ms = (code == 3'h0) ? 12'(iuv_pkg::DELAY2_BASE_MS) :
            (code == 3'h1) ? 12'(iuv_pkg::DELAY2_BASE_MS + iuv_pkg::DELAY2_STEP0_MS) :
            12'(iuv_pkg::DELAY2_BASE_MS + iuv_pkg::DELAY2_STEP0_MS + iuv_pkg::DELAY2_STEP1_MS
                + (int'(code) - 2) * iuv_pkg::DELAY2_STEP_MS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [10:0] warnMant_r, warnMant_nxt;
    logic [10:0] faultMant_r, faultMant_nxt;
    logic [7:0] react_r, react_nxt;
    logic [15:0] rdata_nxt;

    always_comb
    begin
        warnMant_nxt = warnMant_r;
        faultMant_nxt = faultMant_r;
        react_nxt = react_r;
        rdata_nxt = regRdata_r;
        if (regWrite)
        begin
            case (regAddr)
                iuv_pkg::WARN_ADDR: warnMant_nxt = regWdata[iuv_pkg::MANT_MSB:iuv_pkg::MANT_LSB];
                iuv_pkg::FAULT_ADDR: faultMant_nxt = regWdata[iuv_pkg::MANT_MSB:iuv_pkg::MANT_LSB];
                iuv_pkg::REACT_ADDR: react_nxt = regWdata[7:0];
                default: ;
            endcase
        end
        if (regRead)
        begin
            case (regAddr)
                iuv_pkg::WARN_ADDR: rdata_nxt = {exponentSetting, warnMant_r};
                iuv_pkg::FAULT_ADDR: rdata_nxt = {exponentSetting, faultMant_r};
                iuv_pkg::REACT_ADDR: rdata_nxt = {8'h00, react_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            warnMant_r <= iuv_pkg::WARN_RESET;
            faultMant_r <= iuv_pkg::FAULT_RESET;
            react_r <= iuv_pkg::REACT_RESET;
            regRdata_r <= 16'h0000;
        end
        else
        begin
            warnMant_r <= warnMant_nxt;
            faultMant_r <= faultMant_nxt;
            react_r <= react_nxt;
            regRdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic warn_nxt, fault_nxt;

    always_comb
    begin
        warn_nxt = warnFlag_r;
        fault_nxt = faultFlag_r;
        if (senseValid)
        begin
            warn_nxt = inputVoltageSense < scale(warnMant_r, exponentSetting);
            fault_nxt = inputVoltageSense < scale(faultMant_r, exponentSetting);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            warnFlag_r <= 1'b0;
            faultFlag_r <= 1'b0;
        end
        else
        begin
            warnFlag_r <= warn_nxt;
            faultFlag_r <= fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    iuv_pkg::iuv_state_t state_r, state_nxt;
    logic [2:0] retries_r, retries_nxt;
    logic outEn_nxt, latched_nxt;
    logic startT;
    logic [11:0] loadT;
    iuv_pkg::iuv_resp_t resp;
    logic [2:0] retryLimit;
    logic [2:0] delayCode;

    assign resp = iuv_pkg::iuv_resp_t'(react_r[iuv_pkg::RESP_MSB:iuv_pkg::RESP_LSB]);
    assign retryLimit = react_r[iuv_pkg::RETRY_MSB:iuv_pkg::RETRY_LSB];
    assign delayCode = react_r[iuv_pkg::DELAY_MSB:iuv_pkg::DELAY_LSB];
    assign tif.start = startT;
    assign tif.loadMs = loadT;

    always_comb
    begin
        state_nxt = state_r;
        retries_nxt = retries_r;
        outEn_nxt = outputEnable_r;
        latched_nxt = faultLatched_r;
        startT = 1'b0;
        loadT = delay2Ms(delayCode);
        case (state_r)
            iuv_pkg::ST_RUN:
            begin
                outEn_nxt = 1'b1;
                retries_nxt = 3'h0;
                if (faultFlag_r)
                begin
                    case (resp)
                        iuv_pkg::RESP_DELAY:
                        begin
                            startT = 1'b1;
                            loadT = delay1Ms(delayCode);
                            state_nxt = iuv_pkg::ST_DELAY1;
                        end
                        iuv_pkg::RESP_RETRY:
                        begin
                            startT = 1'b1;
                            outEn_nxt = 1'b0;
                            state_nxt = (retryLimit == 3'h0) ? iuv_pkg::ST_LATCHED : iuv_pkg::ST_RETRY_WAIT;
                        end
                        iuv_pkg::RESP_WAIT:
                        begin
                            outEn_nxt = 1'b0;
                            state_nxt = iuv_pkg::ST_OFF_WAIT;
                        end
                        default: ;
                    endcase
                end
            end
            iuv_pkg::ST_DELAY1:
            begin
                if (!faultFlag_r)
                    state_nxt = iuv_pkg::ST_RUN;
                else if (tif.done)
                begin
                    startT = 1'b1;
                    outEn_nxt = 1'b0;
                    state_nxt = (retryLimit == 3'h0) ? iuv_pkg::ST_LATCHED : iuv_pkg::ST_RETRY_WAIT;
                end
            end
            iuv_pkg::ST_OFF_WAIT:
            begin
                if (!faultFlag_r)
                begin
                    outEn_nxt = 1'b1;
                    state_nxt = iuv_pkg::ST_RUN;
                end
            end
            iuv_pkg::ST_RETRY_WAIT:
            begin
                if (tif.done)
                begin
                    if (!faultFlag_r)
                    begin
                        outEn_nxt = 1'b1;
                        state_nxt = iuv_pkg::ST_RUN;
                    end
                    else if (retryLimit != iuv_pkg::RETRY_INFINITE && retries_r + 3'h1 >= retryLimit)
                        state_nxt = iuv_pkg::ST_LATCHED;
                    else
                    begin
                        // Attempt counted unless retries are unlimited; fault still present so the restart is refused
                        startT = 1'b1;
                        if (retryLimit != iuv_pkg::RETRY_INFINITE)
                            retries_nxt = retries_r + 3'h1;
                    end
                end
            end
            iuv_pkg::ST_LATCHED:
            begin
                // Only reset leaves this state
                outEn_nxt = 1'b0;
                latched_nxt = 1'b1;
            end
            default: state_nxt = iuv_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= iuv_pkg::ST_RUN;
            retries_r <= 3'h0;
            outputEnable_r <= 1'b0;
            faultLatched_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            retries_r <= retries_nxt;
            outputEnable_r <= outEn_nxt;
            faultLatched_r <= latched_nxt;
        end
    end
endmodule // iuv_monitor

/* File: iuv_monitor_sva.sv */
// Port assertions for the input undervoltage monitor
`timescale 1ns/1ps
module iuv_monitor_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata_r,
    input wire logic [15:0] inputVoltageSense,
    input wire logic senseValid,
    input wire logic [4:0] exponentSetting,
    input wire logic warnFlag_r,
    input wire logic faultFlag_r,
    input wire logic outputEnable_r,
    input wire logic faultLatched_r
);
    logic [10:0] warnM_r;
    logic [10:0] faultM_r;
    logic [1:0] code_r;
    function automatic longint thr(logic [10:0] m, logic [4:0] e);
        return ((longint'(m) << e) > 64'hFFFF) ? 64'hFFFF : (longint'(m) << e);
    endfunction
    // Shadow copies of both mantissas and the response code, so comparisons need no internal probe
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            warnM_r <= 11'h000;
            faultM_r <= 11'h000;
            code_r <= 2'h0;
        end
        else if (regWrite)
        begin
            if (regAddr == iuv_pkg::WARN_ADDR) warnM_r <= regWdata[10:0];
            if (regAddr == iuv_pkg::FAULT_ADDR) faultM_r <= regWdata[10:0];
            if (regAddr == iuv_pkg::REACT_ADDR) code_r <= regWdata[7:6];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    a_warn_cmp: assert property (senseValid |=>
        warnFlag_r == ($past(inputVoltageSense) < thr($past(warnM_r), $past(exponentSetting))))
        else $error("warning flag wrong");
    a_fault_cmp: assert property (senseValid |=>
        faultFlag_r == ($past(inputVoltageSense) < thr($past(faultM_r), $past(exponentSetting))))
        else $error("fault flag wrong");
    a_read_exp: assert property (regRead && regAddr == iuv_pkg::WARN_ADDR |=>
        regRdata_r[15:11] == $past(exponentSetting)) else $error("exponent field wrong");
    a_read_mant: assert property (regWrite && regAddr == iuv_pkg::WARN_ADDR ##1 !regWrite ##1
        regRead && !regWrite && regAddr == iuv_pkg::WARN_ADDR |=> regRdata_r[10:0] == $past(regWdata[10:0], 3))
        else $error("mantissa readback wrong");
    a_ignore_code: assert property (code_r == 2'b00 && $past(code_r) == 2'b00 && $past(outputEnable_r)
        |-> outputEnable_r) else $error("output dropped with code 00");
    a_delay_keep: assert property ($rose(faultFlag_r) && code_r == 2'b01 && outputEnable_r
        |=> outputEnable_r [*8]) else $error("output dropped before delay one");
    a_retry_off: assert property ($rose(faultFlag_r) && code_r == 2'b10 |-> ##[1:3] !outputEnable_r)
        else $error("output not shut down");
    a_wait_off: assert property ($rose(faultFlag_r) && code_r == 2'b11 |-> ##[1:3] !outputEnable_r)
        else $error("output not disabled on fault");
    a_wait_on: assert property ($fell(faultFlag_r) && code_r == 2'b11 |-> ##2 outputEnable_r)
        else $error("output not restored");
    a_latch_off: assert property (faultLatched_r |-> !outputEnable_r) else $error("output on while latched");
    a_latch_hold: assert property (faultLatched_r |=> faultLatched_r) else $error("latch lost");
endmodule // iuv_monitor_sva

/* File: iuv_monitor_tb.sv */
// Self-checking testbench for the input undervoltage monitor
`timescale 1ns/1ps
module iuv_monitor_tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regWdata = 16'h0000;
    logic [15:0] regRdata_r;
    logic [15:0] inputVoltageSense;
    logic senseValid;
    logic [4:0] exponentSetting = 5'h02;
    logic [15:0] level = 16'h1000;
    logic warnFlag_r, faultFlag_r, outputEnable_r, faultLatched_r;
    logic [15:0] d, e, got;
    int selQ[$];
    logic [15:0] expQ[$];
    int s, n_mismatch = 0, cmp_count = 0;
    string nm[5] = '{"regRdata_r", "warnFlag_r", "faultFlag_r", "outputEnable_r", "faultLatched_r"};
    wire logic [4:0] obs = {faultLatched_r, outputEnable_r, faultFlag_r, warnFlag_r, 1'b0};
    always #25 sys_clk = ~sys_clk;
    iuv_sense_model SRC (.sys_clk(sys_clk), .level(level), .inputVoltageSense(inputVoltageSense),
        .senseValid(senseValid));
    iuv_monitor #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata_r(regRdata_r), .inputVoltageSense(inputVoltageSense),
        .senseValid(senseValid), .exponentSetting(exponentSetting), .warnFlag_r(warnFlag_r),
        .faultFlag_r(faultFlag_r), .outputEnable_r(outputEnable_r), .faultLatched_r(faultLatched_r));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic hold(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic note(int sel, logic [15:0] x);
        selQ.push_back(sel);
        expQ.push_back(x);
        @(posedge sys_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] x);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= x;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] x);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        note(0, x);
    endtask
    task automatic rst();
        rstn <= 1'b0;
        hold(3);
        rstn <= 1'b1;
    endtask
    // Fault threshold 8 << 2 = 32, so 20 is a fault and 1000 is clear
    task automatic arm(logic [15:0] react);
        rst();
        wr(iuv_pkg::FAULT_ADDR, 16'h0008);
        wr(iuv_pkg::REACT_ADDR, react);
        level <= 16'h0014;
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge sys_clk)
    begin
        // Notes are pushed at the rising edge, so outputs have settled by this edge
        while (selQ.size() > 0)
        begin
            s = selQ.pop_front();
            e = expQ.pop_front();
            got = (s == 0) ? regRdata_r : {15'h0000, obs[s]};
            cmp_count++;
            if (got !== e)
            begin
                n_mismatch++;
                $display("unexpected %s: expected %h, seen %h", nm[s], e, got);
            end
        end
    end
    initial
    begin
        hold(5000);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        void'($urandom(32'hDCE3));
        hold(3);
        rstn <= 1'b1;
        d = 16'($urandom);
        exponentSetting <= 5'($urandom);
        wr(iuv_pkg::WARN_ADDR, d);
        rd(iuv_pkg::WARN_ADDR, {exponentSetting, d[10:0]});
        rd(8'h5B, 16'h0000);
        wr(iuv_pkg::REACT_ADDR, d);
        rd(iuv_pkg::REACT_ADDR, {8'h00, d[7:0]});
        $display("register test done");
        exponentSetting <= 5'h02;
        wr(iuv_pkg::WARN_ADDR, 16'h0010);
        wr(iuv_pkg::FAULT_ADDR, 16'h0008);
        wr(iuv_pkg::REACT_ADDR, 16'h0000);
        // Levels 63, 64, 31, 32 against warning limit 64 and fault limit 32
        for (int i = 0; i < 4; i++)
        begin
            level <= 16'(16'h003F - ((i >> 1) * 16'h0020) + (i & 1));
            hold(6);
            note(1, (i == 1) ? 16'h0000 : 16'h0001);
            note(2, (i == 2) ? 16'h0001 : 16'h0000);
            note(3, 16'h0001);
        end
        $display("threshold test done");
        arm(16'h00C0);
        hold(8);
        note(3, 16'h0000);
        level <= 16'h03E8;
        hold(8);
        note(3, 16'h0001);
        arm(16'h0080);
        hold(8);
        note(3, 16'h0000);
        level <= 16'h03E8;
        hold(8);
        note(4, 16'h0001);
        rst();
        note(4, 16'h0000);
        arm(16'h0040);
        hold(30);
        note(3, 16'h0001);
        hold(30);
        note(3, 16'h0000);
        arm(16'h0088);
        hold(900);
        note(4, 16'h0000);
        hold(140);
        note(4, 16'h0001);
        $display("response test done");
        test_done();
    end
endmodule // iuv_monitor_tb
bind iuv_monitor iuv_monitor_sva SVA (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata_r(regRdata_r), .inputVoltageSense(inputVoltageSense),
    .senseValid(senseValid), .exponentSetting(exponentSetting), .warnFlag_r(warnFlag_r),
    .faultFlag_r(faultFlag_r), .outputEnable_r(outputEnable_r), .faultLatched_r(faultLatched_r));

/* File: iuv_ms_timer.sv */
// Millisecond down-counter with one-cycle prescaled enable
`timescale 1ns/1ps
module iuv_ms_timer #(
    parameter int TICK_CYCLES = iuv_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    iuv_timer_if.tmr tif
);
    logic [15:0] preR, preNxt;
    logic [11:0] msR, msNxt;
    logic doneR, doneNxt;
    logic tick;

    assign tif.done = doneR;
    assign tick = (preR == 16'(TICK_CYCLES - 1));

    always_comb
    begin
        preNxt = tick ? 16'h0000 : preR + 16'h0001;
        msNxt = msR;
        doneNxt = 1'b0;
        if (tif.start)
        begin
            msNxt = tif.loadMs;
            preNxt = 16'h0000;
        end
        else if (tick && msR != 12'h000)
        begin
            msNxt = msR - 12'h001;
            doneNxt = (msR == 12'h001);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            preR <= 16'h0000;
            msR <= 12'h000;
            doneR <= 1'b0;
        end
        else
        begin
            preR <= preNxt;
            msR <= msNxt;
            doneR <= doneNxt;
        end
    end
endmodule // iuv_ms_timer

/* File: iuv_pkg.sv */
// Package of register map, field layout and timing constants for the input undervoltage monitor
package iuv_pkg;
    localparam logic [7:0] WARN_ADDR = 8'h58;
    localparam logic [7:0] FAULT_ADDR = 8'h59;
    localparam logic [7:0] REACT_ADDR = 8'h5A;
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MANT_MSB = 10;
    localparam int MANT_LSB = 0;
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [10:0] WARN_RESET = 11'h000;
    localparam logic [10:0] FAULT_RESET = 11'h000;
    localparam logic [7:0] REACT_RESET = 8'h00;
    localparam logic [2:0] RETRY_INFINITE = 3'h7;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int DELAY1_BASE_MS = 10;
    localparam int DELAY2_BASE_MS = 252;
    localparam int DELAY2_STEP0_MS = 306;
    localparam int DELAY2_STEP1_MS = 366;
    localparam int DELAY2_STEP_MS = 336;
    typedef enum logic [1:0] {RESP_IGNORE, RESP_DELAY, RESP_RETRY, RESP_WAIT} iuv_resp_t;
    typedef enum {ST_RUN, ST_DELAY1, ST_OFF_WAIT, ST_RETRY_WAIT, ST_LATCHED} iuv_state_t;
endpackage

/* File: iuv_sense_model.sv */
// Behavioural source of periodic input voltage measurements
`timescale 1ns/1ps
module iuv_sense_model (
    input wire logic sys_clk,
    input wire logic [15:0] level,
    output logic [15:0] inputVoltageSense = 16'h0000,
    output logic senseValid = 1'b0
);
    logic [1:0] phase = 2'h0;
    always @(posedge sys_clk)
    begin
        phase <= phase + 2'h1;
        senseValid <= (phase == 2'h3);
        // Inverse between samples, so a value taken without the strobe shows up
        inputVoltageSense <= (phase == 2'h3) ? level : ~level;
    end
endmodule // iuv_sense_model

/* File: iuv_timer_if.sv */
// Interface between the fault state machine and its millisecond timer
`timescale 1ns/1ps
interface iuv_timer_if;
    logic start;
    logic [11:0] loadMs;
    logic done;
    modport ctl (output start, output loadMs, input done);
    modport tmr (input start, input loadMs, output done);
endinterface
